// ---- logic/rcp_map.svh ----
// register offsets, field positions, reset values and counts of the reset and clock block
// Behaviour
// - Drive chip, core and system reset-request outputs on processor cycles.
// - Processor clock enable low stops the timer and the reset-request outputs; control register writes still take effect.
// - Timer counts synchronised timer-clock edges only when timer select is set.
// - Interconnect clock enable low freezes interconnect-side logic, except that an idle transfer stage still accepts a new request.
// - Integer ratio gives lower core-to-interconnect transfer latency than fractional.
// - Busy output, on interconnect ticks, high while any transaction is active.
// - Chip and system resets clear the whole block; core reset only the core.
// - Each reset is synchronised and stretched for eight interconnect cycles.
// - Core reset is always released last.
// - Debug status records the last reset cause, always the core reset.
// - Restore event repeats the reset sequence; not during active reconfiguration.
// - During configuration the block holds itself in reset, unless reconfiguration is active.
`ifndef RCP_MAP_SVH
`define RCP_MAP_SVH

`define RCP_OFF_CTRL        8'h00
`define RCP_OFF_STATUS      8'h04
`define RCP_OFF_DBG         8'h08
`define RCP_OFF_TIMER       8'h0C

`define RCP_CTRL_TCS_BIT    0
`define RCP_CTRL_REQ_LSB    1
`define RCP_DBG_CAUSE_LSB   0
`define RCP_DBG_SEEN_LSB    2
`define RCP_STAT_SEQ_LSB    0
`define RCP_STAT_BLK_BIT    2
`define RCP_STAT_CORE_BIT   3
`define RCP_STAT_PRUN_BIT   4
`define RCP_STAT_IRUN_BIT   5
`define RCP_STAT_BUSY_BIT   6
`define RCP_STAT_CKOFF_BIT  7
`define RCP_STAT_RATIO_BIT  8
`define RCP_STAT_IDLE_BIT   9

`define RCP_TCS_RESET       1'h0
`define RCP_REQ_RESET       3'h0
`define RCP_CAUSE_NONE      2'h0
`define RCP_CAUSE_CORE      2'h2
`define RCP_SEEN_RESET      3'h0
`define RCP_TIMER_RESET     32'h0000_0000

`define RCP_STRETCH_CYCLES  8
`define RCP_PEND_INTEGER    2'h1
`define RCP_PEND_FRACTIONAL 2'h2

`endif

// ---- logic/rcp_pkg.sv ----
// types shared by the reset and clock block
`include "rcp_map.svh"
package rcp_pkg;
    typedef enum logic [1:0] {
        SQ_BLOCK = 2'b00,
        SQ_CORE  = 2'b01,
        SQ_RUN   = 2'b11,
        SQ_CFG   = 2'b10
    } rcp_seq_e;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } rcp_bus_s;

    typedef struct packed {
        logic sys_bus;
        logic dma;
        logic mem;
    } rcp_activity_s;

    typedef struct packed {
        logic chip;
        logic core;
        logic system;
        logic pen;
        logic ic_en;
        logic ratio_int;
        logic clk_off;
        logic timer;
        logic cfg;
        logic reconf;
        logic restore;
    } rcp_pins_s;

    typedef struct packed {
        logic [4:0] cnt;
        logic       odd;
        logic       tick;
    } rcp_div_s;

    typedef struct packed {
        rcp_seq_e    seq;
        logic [2:0]  cnt;
        logic        timer_clock_select;
        logic [2:0]  req_ctrl;
        logic [2:0]  req_out;
        logic        blk_rst;
        logic        core_rst;
        logic        proc_run;
        logic        ic_run;
        logic        busy;
        logic [1:0]  cause;
        logic [2:0]  seen;
        logic [1:0]  pend;
        logic        issue;
        logic        xfer_idle;
        logic        timer_prev;
        logic        restore_prev;
        logic [31:0] timer;
        logic [31:0] rdata;
    } rcp_state_s;
endpackage : rcp_pkg

// ---- logic/rcp_sync.sv ----
// two flip-flop synchroniser for a bundle of asynchronous pins
`timescale 1ns/1ps
module rcp_sync #(
    parameter int unsigned WIDTH = 1
) (
    // clock and reset
    input wire logic             core_clk,
    input wire logic             reset,
    // asynchronous pins and their synchronised copy
    input wire logic [WIDTH-1:0] d_in,
    output logic     [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] stable_reg;

    // first stage feeds only the second
    always_ff @(posedge core_clk) begin
        if (reset) begin
            meta_reg   <= '0;
            stable_reg <= '0;
        end else begin
            meta_reg   <= d_in;
            stable_reg <= meta_reg;
        end
    end

    assign q_out = stable_reg;
endmodule : rcp_sync

// ---- logic/rcp_ratio_div.sv ----
// interconnect tick divider for integer and fractional clock ratios
`timescale 1ns/1ps
module rcp_ratio_div
    import rcp_pkg::*;
#(
    parameter int unsigned RATIO_N = 2
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // ratio mode and tick
    input wire logic integer_mode,
    output logic     tick
);
    localparam logic [4:0] LIMIT_INT = 5'(RATIO_N - 1);
    localparam logic [4:0] LIMIT_ODD = 5'(RATIO_N);

    rcp_div_s st_reg;
    rcp_div_s st_next;
    logic [4:0] limit;

    // fractional mode alternates N and N+1 cycles, averaging (2N+1)/2
    always_comb begin
        st_next      = st_reg;
        limit        = (!integer_mode && st_reg.odd) ? LIMIT_ODD : LIMIT_INT;
        st_next.tick = 1'b0;
        if (st_reg.cnt >= limit) begin
            st_next.cnt  = '0;
            st_next.odd  = ~st_reg.odd;
            st_next.tick = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt + 5'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tick = st_reg.tick;
endmodule : rcp_ratio_div

// ---- logic/rcp_top.sv ----
// reset sequencer, clock enables, busy and timer logic of the processor block
`timescale 1ns/1ps
`include "rcp_map.svh"
module rcp_top
    import rcp_pkg::*;
#(
    parameter int unsigned RATIO_N = 2
) (
    // clock and reset
    input wire logic          core_clk,
    input wire logic          reset,
    // asynchronous reset pins
    input wire logic          chip_reset_in,
    input wire logic          core_reset_in,
    input wire logic          system_reset_in,
    // clock control pins
    input wire logic          processor_clock_enable,
    input wire logic          interconnect_clock_enable,
    input wire logic          integer_ratio_select,
    input wire logic          core_clock_off_indication,
    input wire logic          timer_clock_in,
    // configuration pins
    input wire logic          config_active_in,
    input wire logic          reconfig_active_in,
    input wire logic          global_restore_in,
    // activity sources and core transfer requests
    input rcp_activity_s      activity_in,
    input wire logic          xfer_req_in,
    // register port
    input rcp_bus_s           bus_in,
    output logic [31:0]       rd_data_out,
    // reset requests
    output logic              chip_reset_request_out,
    output logic              core_reset_request_out,
    output logic              system_reset_request_out,
    // sequenced resets and enables
    output logic              block_reset_out,
    output logic              core_reset_out,
    output logic              processor_run_out,
    output logic              interconnect_run_out,
    // interconnect side
    output logic              interconnect_busy_out,
    output logic              xfer_issue_out,
    output logic              xfer_idle_out
);
    localparam logic [2:0] STRETCH_LAST = 3'(`RCP_STRETCH_CYCLES - 1);

    rcp_state_s st_reg;
    rcp_state_s st_next;
    rcp_pins_s  pins_raw;
    rcp_pins_s  pins_s;
    logic       div_tick;
    logic       ic_tick;
    logic       blk_req;
    logic       restore_edge;
    logic       timer_step;
    logic [31:0] status_word;

    function automatic logic is_block_state(input rcp_seq_e s);
        is_block_state = (s == SQ_BLOCK) || (s == SQ_CFG);
    endfunction : is_block_state

    assign pins_raw = '{chip: chip_reset_in, core: core_reset_in, system: system_reset_in,
                        pen: processor_clock_enable, ic_en: interconnect_clock_enable,
                        ratio_int: integer_ratio_select, clk_off: core_clock_off_indication,
                        timer: timer_clock_in, cfg: config_active_in,
                        reconf: reconfig_active_in, restore: global_restore_in};

    rcp_sync #(
        .WIDTH ($bits(rcp_pins_s))
    ) u_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .d_in     (pins_raw),
        .q_out    (pins_s)
    );

    rcp_ratio_div #(
        .RATIO_N (RATIO_N)
    ) u_div (
        .core_clk     (core_clk),
        .reset        (reset),
        .integer_mode (pins_s.ratio_int),
        .tick         (div_tick)
    );

    assign ic_tick      = div_tick & pins_s.ic_en;
    assign restore_edge = pins_s.restore & ~st_reg.restore_prev & ~pins_s.reconf;
    assign blk_req      = pins_s.chip | pins_s.system | restore_edge;
    assign timer_step   = st_reg.timer_clock_select ? (pins_s.timer & ~st_reg.timer_prev) : 1'b1;

    always_comb begin
        status_word = '0;
        status_word[`RCP_STAT_SEQ_LSB +: 2] = st_reg.seq;
        status_word[`RCP_STAT_BLK_BIT]      = st_reg.blk_rst;
        status_word[`RCP_STAT_CORE_BIT]     = st_reg.core_rst;
        status_word[`RCP_STAT_PRUN_BIT]     = st_reg.proc_run;
        status_word[`RCP_STAT_IRUN_BIT]     = st_reg.ic_run;
        status_word[`RCP_STAT_BUSY_BIT]     = st_reg.busy;
        status_word[`RCP_STAT_CKOFF_BIT]    = pins_s.clk_off;
        status_word[`RCP_STAT_RATIO_BIT]    = pins_s.ratio_int;
        status_word[`RCP_STAT_IDLE_BIT]     = st_reg.xfer_idle;
    end

    always_comb begin
        st_next              = st_reg;
        st_next.rdata        = '0;
        st_next.issue        = 1'b0;
        st_next.timer_prev   = pins_s.timer;
        st_next.restore_prev = pins_s.restore;

        // reset sequencer: block reset stretched, then core reset stretched
        case (st_reg.seq)
            SQ_CFG: begin
                st_next.seq = SQ_BLOCK;
                st_next.cnt = '0;
            end
            SQ_BLOCK: begin
                if (blk_req) begin
                    st_next.cnt = '0;
                end else if (ic_tick) begin
                    if (st_reg.cnt == STRETCH_LAST) begin
                        st_next.seq = SQ_CORE;
                        st_next.cnt = '0;
                    end else begin
                        st_next.cnt = st_reg.cnt + 3'h1;
                    end
                end
            end
            SQ_CORE: begin
                if (blk_req) begin
                    st_next.seq = SQ_BLOCK;
                    st_next.cnt = '0;
                end else if (pins_s.core) begin
                    st_next.cnt = '0;
                end else if (ic_tick) begin
                    if (st_reg.cnt == STRETCH_LAST) begin
                        st_next.seq   = SQ_RUN;
                        st_next.cause = `RCP_CAUSE_CORE;
                    end else begin
                        st_next.cnt = st_reg.cnt + 3'h1;
                    end
                end
            end
            SQ_RUN: begin
                if (blk_req) begin
                    st_next.seq = SQ_BLOCK;
                    st_next.cnt = '0;
                end else if (pins_s.core) begin
                    st_next.seq = SQ_CORE;
                    st_next.cnt = '0;
                end
            end
            default: begin
                st_next.seq = SQ_BLOCK;
                st_next.cnt = '0;
            end
        endcase
        // configuration holds everything in reset unless reconfiguring live
        if (pins_s.cfg && !pins_s.reconf) begin
            st_next.seq = SQ_CFG;
            st_next.cnt = '0;
        end

        st_next.blk_rst  = is_block_state(st_next.seq);
        st_next.core_rst = (st_next.seq != SQ_RUN);
        st_next.proc_run = pins_s.pen & (st_next.seq == SQ_RUN);
        st_next.ic_run   = pins_s.ic_en;

        // sources seen since software last cleared them; a new one wins over the clear
        if (bus_in.wr && bus_in.addr == `RCP_OFF_DBG) begin
            st_next.seen = st_reg.seen & ~bus_in.wdata[`RCP_DBG_SEEN_LSB +: 3];
        end
        st_next.seen = st_next.seen | {pins_s.chip, pins_s.core, pins_s.system};

        // processor-side state, advanced only on running processor cycles
        if (st_reg.core_rst) begin
            st_next.timer    = `RCP_TIMER_RESET;
            st_next.req_ctrl = `RCP_REQ_RESET;
            st_next.req_out  = `RCP_REQ_RESET;
        end else if (st_reg.proc_run) begin
            st_next.req_out = st_reg.req_ctrl;
            if (timer_step) begin
                st_next.timer = st_reg.timer + 32'h0000_0001;
            end
        end
        if (bus_in.wr && bus_in.addr == `RCP_OFF_CTRL) begin
            st_next.timer_clock_select = bus_in.wdata[`RCP_CTRL_TCS_BIT];
            if (!st_reg.core_rst) begin
                st_next.req_ctrl = bus_in.wdata[`RCP_CTRL_REQ_LSB +: 3];
            end
        end

        // core-to-interconnect transfer: fractional ratio costs one extra tick
        if (st_reg.blk_rst) begin
            st_next.pend = '0;
        end else if (st_reg.pend == 2'h0) begin
            if (xfer_req_in) begin
                st_next.pend = pins_s.ratio_int ? `RCP_PEND_INTEGER
                                                : `RCP_PEND_FRACTIONAL;
            end
        end else if (ic_tick) begin
            st_next.pend  = st_reg.pend - 2'h1;
            st_next.issue = (st_reg.pend == 2'h1);
        end
        st_next.xfer_idle = (st_next.pend == 2'h0);

        if (ic_tick) begin
            st_next.busy = activity_in.sys_bus | activity_in.dma | activity_in.mem
                         | (st_reg.pend != 2'h0);
        end

        if (bus_in.rd) begin
            case (bus_in.addr)
                `RCP_OFF_CTRL: begin
                    st_next.rdata[`RCP_CTRL_TCS_BIT]      = st_reg.timer_clock_select;
                    st_next.rdata[`RCP_CTRL_REQ_LSB +: 3] = st_reg.req_ctrl;
                end
                `RCP_OFF_STATUS: begin
                    st_next.rdata = status_word;
                end
                `RCP_OFF_DBG: begin
                    st_next.rdata[`RCP_DBG_CAUSE_LSB +: 2] = st_reg.cause;
                    st_next.rdata[`RCP_DBG_SEEN_LSB +: 3]  = st_reg.seen;
                end
                `RCP_OFF_TIMER: begin
                    st_next.rdata = st_reg.timer;
                end
                default: begin
                    st_next.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_reg              <= '0;
            st_reg.seq          <= SQ_BLOCK;
            st_reg.timer_clock_select          <= `RCP_TCS_RESET;
            st_reg.req_ctrl     <= `RCP_REQ_RESET;
            st_reg.req_out      <= `RCP_REQ_RESET;
            st_reg.blk_rst      <= 1'b1;
            st_reg.core_rst     <= 1'b1;
            st_reg.cause        <= `RCP_CAUSE_NONE;
            st_reg.seen         <= `RCP_SEEN_RESET;
            st_reg.xfer_idle    <= 1'b1;
            st_reg.timer        <= `RCP_TIMER_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rd_data_out              = st_reg.rdata;
    assign chip_reset_request_out   = st_reg.req_out[2];
    assign core_reset_request_out   = st_reg.req_out[1];
    assign system_reset_request_out = st_reg.req_out[0];
    assign block_reset_out          = st_reg.blk_rst;
    assign core_reset_out           = st_reg.core_rst;
    assign processor_run_out        = st_reg.proc_run;
    assign interconnect_run_out     = st_reg.ic_run;
    assign interconnect_busy_out    = st_reg.busy;
    assign xfer_issue_out           = st_reg.issue;
    assign xfer_idle_out            = st_reg.xfer_idle;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    core_last_a: assert property ($fell(block_reset_out) |-> core_reset_out)
        else $error("block reset released while core reset not held");
    stretch_full_a: assert property ($fell(core_reset_out) |-> $past(st_reg.cnt) == STRETCH_LAST
        && $past(st_reg.seq) == SQ_CORE)
        else $error("core reset released before full stretch");
    cause_core_a: assert property ($fell(core_reset_out)
        |-> st_reg.cause == `RCP_CAUSE_CORE)
        else $error("last reset cause not core");
    busy_set_a: assert property (ic_tick && (activity_in.dma || activity_in.mem
        || activity_in.sys_bus) |=> interconnect_busy_out)
        else $error("busy low while transaction active");
    ic_freeze_a: assert property (!pins_s.ic_en |=> $stable(interconnect_busy_out)
        && $stable(st_reg.pend))
        else $error("interconnect logic moved while disabled");
    proc_gate_a: assert property (!processor_run_out && !core_reset_out
        |=> $stable(st_reg.timer))
        else $error("timer advanced with processor clock off");
    timer_free_a: assert property (processor_run_out && !st_reg.timer_clock_select && !core_reset_out
        |=> st_reg.timer == $past(st_reg.timer) + 32'h0000_0001)
        else $error("timer did not count processor cycle");
    timer_sel_a: assert property (processor_run_out && st_reg.timer_clock_select && !core_reset_out
        && !(pins_s.timer && !st_reg.timer_prev) |=> $stable(st_reg.timer))
        else $error("timer counted without timer clock edge");
    req_out_a: assert property (processor_run_out && st_reg.req_ctrl[2] && !core_reset_out
        |=> chip_reset_request_out)
        else $error("chip reset request not driven");
    cfg_hold_a: assert property (pins_s.cfg && !pins_s.reconf
        |=> block_reset_out && core_reset_out)
        else $error("block not held in reset during configuration");
    restore_a: assert property (restore_edge |=> block_reset_out)
        else $error("restore event did not repeat reset");
    sync_delay_a: assert property ($rose(chip_reset_in) && !block_reset_out
        |=> !block_reset_out)
        else $error("reset pin acted without synchroniser delay");
    int_latency_a: assert property (xfer_req_in && xfer_idle_out && pins_s.ratio_int
        && !block_reset_out ##1 ic_tick |=> xfer_issue_out)
        else $error("integer ratio transfer not issued on first tick");

    run_cov: cover property ($fell(core_reset_out));
    frac_cov: cover property (xfer_issue_out && !pins_s.ratio_int);
    restart_cov: cover property (restore_edge ##[1:200] $fell(core_reset_out));
    core_only_cov: cover property (st_reg.seq == SQ_RUN ##1 st_reg.seq == SQ_CORE);
endmodule : rcp_top

// ---- verification/rcp_mgr_model.sv ----
// clock, reset and power manager model that drives the block pins
`timescale 1ns/1ps
module rcp_mgr_model
    import rcp_pkg::*;
(
    // clock; the only clock, so edges are aligned by construction
    input wire logic core_clk,
    // block status
    input wire logic interconnect_busy_out,
    // manager pins
    output rcp_pins_s pins_out
);
    logic [1:0] tdiv = 2'h0;

    initial begin
        pins_out = '0;
        pins_out.pen = 1'b1;
        pins_out.ic_en = 1'b1;
        pins_out.ratio_int = 1'b1;
    end

    // timer clock at a quarter of the processor rate
    always @(posedge core_clk) begin
        tdiv <= tdiv + 2'h1;
        if (tdiv[0]) begin
            pins_out.timer <= !pins_out.timer;
        end
        pins_out.clk_off <= !pins_out.pen;
    end

    task automatic drive(input int idx, input logic v);
        @(posedge core_clk);
        pins_out[idx] <= v;
    endtask : drive

    task automatic pulse_reset(input int idx);
        for (int i = 0; i < 50 && interconnect_busy_out !== 1'b0; i++) begin
            @(posedge core_clk);
            #1;
        end
        @(posedge core_clk);
        pins_out[idx] <= 1'b1;
        repeat (4) @(posedge core_clk);
        pins_out[idx] <= 1'b0;
    endtask : pulse_reset
endmodule : rcp_mgr_model

// ---- verification/cpu_block_reset_clock_pm_test.sv ----
// self-checking bench of the reset, clock and power block
`timescale 1ns/1ps
module cpu_block_reset_clock_pm_test
    import rcp_pkg::*;
;
    localparam int P_CORE = 9;
    localparam int P_PEN = 7;
    localparam int P_ICEN = 6;
    localparam int P_RATIO = 5;
    localparam int P_CFG = 2;
    localparam int P_RECONF = 1;
    localparam int P_RESTORE = 0;
    logic          core_clk = 1'b0;
    logic          reset    = 1'b1;
    rcp_pins_s     pins;
    rcp_activity_s act      = '0;
    logic          xreq     = 1'b0;
    rcp_bus_s      bus      = '0;
    logic [31:0]   rdata;
    logic          creq, kreq, sreq, blk, core, prun, irun, busy, issue, idle;
    logic [31:0]   t0, t1;
    int            g, lat_i, lat_f;
    int            mismatches = 0;
    int            compares   = 0;

    always #4 core_clk = ~core_clk;

    rcp_mgr_model u_mgr (.core_clk(core_clk), .interconnect_busy_out(busy), .pins_out(pins));

    rcp_top #(.RATIO_N(1)) u_dut (
        .core_clk(core_clk), .reset(reset), .chip_reset_in(pins.chip),
        .core_reset_in(pins.core), .system_reset_in(pins.system),
        .processor_clock_enable(pins.pen), .interconnect_clock_enable(pins.ic_en),
        .integer_ratio_select(pins.ratio_int), .core_clock_off_indication(pins.clk_off),
        .timer_clock_in(pins.timer), .config_active_in(pins.cfg),
        .reconfig_active_in(pins.reconf), .global_restore_in(pins.restore),
        .activity_in(act), .xfer_req_in(xreq), .bus_in(bus), .rd_data_out(rdata),
        .chip_reset_request_out(creq), .core_reset_request_out(kreq),
        .system_reset_request_out(sreq), .block_reset_out(blk), .core_reset_out(core),
        .processor_run_out(prun), .interconnect_run_out(irun),
        .interconnect_busy_out(busy), .xfer_issue_out(issue), .xfer_idle_out(idle));

    task automatic chk1(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t bit %b expected %b", $time, got, exp);
        end
    endtask : chk1

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk32

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge core_clk);
            #1;
        end
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask : rd

    // waits for block release, then counts cycles until the core leaves reset
    task automatic wait_release(output int gap);
        gap = 0;
        for (int i = 0; i < 100 && blk !== 1'b0; i++) tick(1);
        chk1(core, 1'b1);
        while (core !== 1'b0 && gap < 100) begin
            tick(1);
            gap++;
        end
    endtask : wait_release

    // mid-run reset with a new ratio, then the start's release checks without the run check, gap checked only for integer ratio
    task automatic restart(input logic ratio);
        u_mgr.drive(P_RATIO, ratio);
        reset <= 1'b1;
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        tick(1);
        chk1(blk & core & idle & !prun, 1'b1);
        wait_release(g);
        if (ratio) chk32(g, 8);
    endtask : restart

    task automatic xfer_lat(output int lat);
        @(posedge core_clk);
        xreq <= 1'b1;
        @(posedge core_clk);
        xreq <= 1'b0;
        lat = 0;
        #1;
        while (issue !== 1'b1 && lat < 20) begin
            tick(1);
            lat++;
        end
        tick(1);
        chk1(issue, 1'b0);
    endtask : xfer_lat

    task automatic s_regs;
        wr(8'h00, 32'h0000_000E);
        tick(2);
        chk1(creq & kreq & sreq, 1'b1);
        rd(8'h10, t0);
        chk32(t0, 32'h0);
        wr(8'h00, 32'h0);
        tick(2);
        chk1(creq | kreq | sreq, 1'b0);
    endtask : s_regs

    task automatic s_resets;
        for (int k = 0; k < 3; k++) begin
            u_mgr.pulse_reset(10 - k);
            tick(1);
            chk1(blk, k != 1);
            chk1(core, 1'b1);
            wait_release(g);
            if (k != 1) chk32(g, 8);
            rd(8'h08, t0);
            chk32(t0[1:0], 32'h2);
            chk1(t0[4 - k], 1'b1);
            wr(8'h08, 32'h1C);
        end
    endtask : s_resets

    task automatic s_timer;
        rd(8'h0C, t0);
        tick(40);
        rd(8'h0C, t1);
        chk32(t1 - t0, 32'h0000_002A);
        wr(8'h00, 32'h1);
        rd(8'h0C, t0);
        tick(40);
        rd(8'h0C, t1);
        chk1(t1 - t0 >= 8 && t1 - t0 <= 14, 1'b1);
        u_mgr.drive(P_PEN, 1'b0);
        tick(4);
        chk1(prun, 1'b0);
        rd(8'h04, t0);
        chk32(t0, 32'h0000_03A3);
        u_mgr.drive(P_PEN, 1'b1);
        u_mgr.drive(P_ICEN, 1'b0);
        tick(4);
        chk1(irun, 1'b0);
        u_mgr.drive(P_ICEN, 1'b1);
        tick(4);
        chk1(irun & prun, 1'b1);
    endtask : s_timer

    task automatic s_busy;
        for (int k = 0; k < 3; k++) begin
            @(posedge core_clk);
            act <= rcp_activity_s'(3'h1 << k);
            tick(4);
            chk1(busy, 1'b1);
            @(posedge core_clk);
            act <= '0;
            tick(4);
            chk1(busy, 1'b0);
        end
        xfer_lat(lat_i);
        restart(1'b0);
        xfer_lat(lat_f);
        chk1(lat_i < lat_f, 1'b1);
        restart(1'b1);
    endtask : s_busy

    task automatic s_cfg;
        u_mgr.drive(P_CFG, 1'b1);
        tick(5);
        chk1(blk, 1'b1);
        u_mgr.drive(P_CFG, 1'b0);
        wait_release(g);
        u_mgr.drive(P_RECONF, 1'b1);
        u_mgr.drive(P_RESTORE, 1'b1);
        tick(5);
        chk1(blk | core, 1'b0);
        u_mgr.pulse_reset(P_CORE);
        tick(1);
        chk1(core, 1'b1);
        wait_release(g);
        u_mgr.drive(P_RESTORE, 1'b0);
        u_mgr.drive(P_RECONF, 1'b0);
        u_mgr.drive(P_RESTORE, 1'b1);
        tick(5);
        chk1(blk, 1'b1);
        u_mgr.drive(P_RESTORE, 1'b0);
        wait_release(g);
        chk32(g, 8);
    endtask : s_cfg

    task automatic results;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results

    initial begin
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        tick(1);
        chk1(blk & core & idle & !prun, 1'b1);
        wait_release(g);
        chk32(g, 8);
        chk1(prun, 1'b1);
        s_regs();
        s_resets();
        s_timer();
        s_busy();
        s_cfg();
        results();
    end

    initial begin
        #100000;
        mismatches++;
        results();
    end
endmodule : cpu_block_reset_clock_pm_test
